//--- src/dwd_top.sv
// Dual watchdog: windowed watchdog and free-running watchdog
`timescale 1ns/1ps

module dwd_top
	import dwd_pkg::*;
(
	input wire logic clk_sys, // System clock
	input wire logic rstn, // Async reset, active low
	input wire logic oscLowTick, // Low-speed oscillator tick, one cycle
	input wire logic optWinEnable, // Option strap: windowed active at start
	input wire logic optFrEnable, // Option strap: free-running active at start
	input wire dwd_win_cfg_s winCfg, // Windowed start and refresh data
	input wire logic winWrite, // Strobe for winCfg
	input wire dwd_fr_cfg_s frCfg, // Free-running command and setup
	input wire logic frWrite, // Strobe for frCfg
	output logic resetReq, // Device reset request, level
	output dwd_cause_s resetCause, // Which watchdog fired
	output logic winActive, // Windowed watchdog running
	output logic frActive, // Free-running watchdog running
	output logic [WIN_W-1:0] winCount // Windowed counter value
);

	// ------------------------------------------------------------
	// Startup strap capture
	// ------------------------------------------------------------
	// Straps sampled by a clocked process after release, never under reset
	logic strapDone;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			strapDone <= 1'b0;
		end else begin
			strapDone <= 1'b1;
		end
	end
	logic strapTake;
	// High for the first edge after release only
	assign strapTake = !strapDone;

	// ------------------------------------------------------------
	// Windowed watchdog prescaler
	// ------------------------------------------------------------
	// Free-running so refreshes do not stretch the tick period
	logic [WIN_PRE_W-1:0] winPre;
	logic winTick;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			winPre <= '0;
			winTick <= 1'b0;
		end else if (winPre == WIN_PRE_W'(WIN_PRESCALE - 1)) begin
			winPre <= '0;
			winTick <= 1'b1;
		end else begin
			winPre <= winPre + 1'b1;
			winTick <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Windowed watchdog
	// ------------------------------------------------------------
	logic [WIN_W-1:0] winLimit;
	logic winFire;
	logic winEarlyFire;
	logic winStartCmd;
	logic winRefresh;
	logic winEarly;
	assign winStartCmd = winWrite && winCfg.start;
	// Refresh is any write while running; start also loads count
	assign winRefresh = winWrite && winActive;
	// Early refresh: counter still above window value
	// Old limit applies; a new one only guards the next refresh
	assign winEarly = winRefresh && (winCount > winLimit);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			winActive <= 1'b0;
		end else if ((strapTake && optWinEnable) || winStartCmd) begin
			winActive <= 1'b1;
		end
		// No path clears it short of reset
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			winCount <= WIN_CNT_RST;
			winLimit <= WIN_LIMIT_RST;
		end else if (winWrite) begin
			winCount <= winCfg.count;
			winLimit <= winCfg.limit;
		end else if (winActive && winTick) begin
			winCount <= winCount - 7'h01;
		end
	end

	// Expiry when bit 6 would clear: count leaves WIN_EXPIRE going down
	// A refresh in the cycle of the last tick still saves the device
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			winFire <= 1'b0;
		end else begin
			winFire <= winActive && winTick && !winWrite &&
				(winCount == WIN_EXPIRE);
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			winEarlyFire <= 1'b0;
		end else begin
			winEarlyFire <= winEarly;
		end
	end

	// ------------------------------------------------------------
	// Free-running watchdog
	// ------------------------------------------------------------
	// Last prescaler count for a select: (4 << sel) - 1
	// One spare bit so the top select reaches 512 ticks, about 4 ms at 128 kHz
	function automatic logic [FR_DIV_W-1:0] frDivLast(input logic [FR_PRE_W-1:0] sel);
		logic [FR_DIV_W:0] span;
		span = FR_PRE_BASE << sel;
		span = span - 10'h001;
		return span[FR_DIV_W-1:0];
	endfunction

	logic [FR_DIV_W-1:0] frPre;
	logic [FR_W-1:0] frCount;
	logic [FR_W-1:0] frReload;
	logic [FR_PRE_W-1:0] frPreSel;
	logic frFire;
	logic frStartCmd;
	logic frRefreshCmd;
	logic [FR_DIV_W-1:0] frPreLast;
	assign frStartCmd = frWrite && (frCfg.cmd == DWD_CMD_START);
	assign frRefreshCmd = frWrite && (frCfg.cmd == DWD_CMD_REFRESH);
	assign frPreLast = frDivLast(frPreSel);

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			frActive <= 1'b0;
		end else if ((strapTake && optFrEnable) || frStartCmd) begin
			frActive <= 1'b1;
		end
	end

	// Setup only taken while stopped
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			frReload <= FR_RELOAD_RST;
			frPreSel <= FR_PRE_RST;
		end else if (frWrite && !frActive && frCfg.cmd == DWD_CMD_NONE) begin
			frReload <= frCfg.reload;
			frPreSel <= frCfg.prescale;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			frPre <= '0;
			frCount <= FR_RELOAD_RST;
			frFire <= 1'b0;
		end else begin
			frFire <= 1'b0;
			// Held at reload while stopped so a start counts a full period
			if (!frActive || frRefreshCmd) begin
				frCount <= frReload;
				frPre <= '0;
			end else if (oscLowTick) begin
				if (frPre >= frPreLast) begin
					frPre <= '0;
					if (frCount == '0) begin
						frFire <= 1'b1;
					end else begin
						frCount <= frCount - 8'h01;
					end
				end else begin
					frPre <= frPre + 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Reset request
	// ------------------------------------------------------------
	// Held until the system reset pulls rstn; either source suffices
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			resetReq <= 1'b0;
		end else if (winFire || winEarlyFire || frFire) begin
			resetReq <= 1'b1;
		end
	end

	// Cause bits accumulate; a later firing of the other watchdog adds its bit
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			resetCause <= '0;
		end else begin
			if (winFire) begin
				resetCause.winTimeout <= 1'b1;
			end
			if (winEarlyFire) begin
				resetCause.winEarly <= 1'b1;
			end
			if (frFire) begin
				resetCause.frTimeout <= 1'b1;
			end
		end
	end

endmodule

//--- src/dwd_pkg.sv
// Package of constants and types for the dual watchdog system
package dwd_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int CLK_SYS_HZ = 100_000_000;
	localparam int OSC_LOW_HZ = 128_000;
	// Low-speed tick period in system clocks (rounded down)
	localparam int OSC_DIV = CLK_SYS_HZ / OSC_LOW_HZ;
	// Window prescale in system clocks
	localparam int WIN_PRESCALE = 12288;
	localparam int WIN_PRE_W = 14;

	// ------------------------------------------------------------
	// Windowed watchdog
	// ------------------------------------------------------------
	localparam int WIN_W = 7;
	localparam logic [WIN_W-1:0] WIN_CNT_RST = 7'h7F;
	localparam logic [WIN_W-1:0] WIN_LIMIT_RST = 7'h7F;
	localparam int WIN_MSB = WIN_W - 1;
	// Expiry point: the last tick seen at this count fires
	localparam logic [WIN_W-1:0] WIN_EXPIRE = 7'h40;

	// ------------------------------------------------------------
	// Free-running watchdog
	// ------------------------------------------------------------
	localparam int FR_W = 8;
	localparam int FR_PRE_W = 3;
	localparam logic [FR_W-1:0] FR_RELOAD_RST = 8'hFF;
	localparam logic [FR_PRE_W-1:0] FR_PRE_RST = 3'h0;
	localparam logic [7:0] FR_PRE_MAX = 8'hFF;
	// Prescaler count width and its base span of four ticks
	localparam int FR_DIV_W = 9;
	localparam logic [FR_DIV_W:0] FR_PRE_BASE = 10'h004;

	// Software commands to the free-running watchdog
	typedef enum logic [1:0] {
		DWD_CMD_NONE,
		DWD_CMD_START,
		DWD_CMD_REFRESH
	} dwd_cmd_e;

	// Configuration from software writes, and the reset cause record
	typedef struct packed {
		logic start;
		logic [WIN_W-1:0] count;
		logic [WIN_W-1:0] limit;
	} dwd_win_cfg_s;

	typedef struct packed {
		dwd_cmd_e cmd;
		logic [FR_W-1:0] reload;
		logic [FR_PRE_W-1:0] prescale;
	} dwd_fr_cfg_s;

	typedef struct packed {
		logic winTimeout;
		logic winEarly;
		logic frTimeout;
	} dwd_cause_s;

endpackage

//--- test/dwd_checker.sv
// Port checker for the dual watchdog
`timescale 1ns/1ps
module dwd_checker import dwd_pkg::*; (
	input wire logic clk_sys, // Clock
	input wire logic rstn, // Reset, active low
	input wire dwd_win_cfg_s winCfg, // Window data
	input wire logic winWrite, // Window strobe
	input wire dwd_fr_cfg_s frCfg, // Free data
	input wire logic frWrite, // Free strobe
	input wire logic resetReq, // Reset request
	input wire dwd_cause_s resetCause, // Cause
	input wire logic winActive, // Window running
	input wire logic frActive, // Free running
	input wire logic [WIN_W-1:0] winCount // Counter
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// Mirror of the stored window limit
	logic [WIN_W-1:0] lim;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) lim <= WIN_LIMIT_RST;
		else if (winWrite) lim <= winCfg.limit;
	end
	sequence early_s; winWrite && winActive && (winCount > lim); endsequence
	sequence frgo_s; frWrite && (frCfg.cmd == DWD_CMD_START); endsequence
	req_sticky_a: assert property (resetReq |=> resetReq) else $error("request dropped");
	win_stays_a: assert property (winActive |=> winActive) else $error("window stopped");
	fr_stays_a: assert property (frActive |=> frActive) else $error("free stopped");
	cause_set_a: assert property ($rose(resetReq) |-> |resetCause) else $error("no cause");
	win_start_a: assert property (winWrite && winCfg.start |=> winActive) else $error("no start");
	fr_start_a: assert property (frgo_s |=> frActive) else $error("free no start");
	early_fault_a: assert property (early_s |-> ##2 resetCause.winEarly) else $error("no early");
	win_load_a: assert property (winWrite |=> winCount == $past(winCfg.count)) else $error("load");
	win_expire_a: assert property ($rose(resetCause.winTimeout) |-> $past(winCount, 2) == WIN_EXPIRE)
		else $error("bad expiry");
	fr_fire_a: assert property ($rose(resetCause.frTimeout) |-> frActive) else $error("idle fire");
endmodule
bind dwd_top dwd_checker chk_i (.clk_sys(clk_sys), .rstn(rstn), .winCfg(winCfg),
	.winWrite(winWrite), .frCfg(frCfg), .frWrite(frWrite), .resetReq(resetReq),
	.resetCause(resetCause), .winActive(winActive), .frActive(frActive), .winCount(winCount));

//--- test/testbench.sv
// Self-checking bench for the dual watchdog
`timescale 1ns/1ps
module testbench import dwd_pkg::*; ;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic tick = 1'b0;
	logic optW = 1'b0;
	logic optF = 1'b0;
	logic winWrite = 1'b0;
	logic frWrite = 1'b0;
	dwd_win_cfg_s winCfg = '0;
	dwd_fr_cfg_s frCfg = '0;
	logic resetReq;
	logic winActive;
	logic frActive;
	dwd_cause_s resetCause;
	logic [WIN_W-1:0] winCount;
	int fails = 0;
	int totalChecks = 0;
	int n;
	always #5 clk_sys = ~clk_sys;
	dwd_top dut (.clk_sys(clk_sys), .rstn(rstn), .oscLowTick(tick), .optWinEnable(optW),
		.optFrEnable(optF), .winCfg(winCfg), .winWrite(winWrite), .frCfg(frCfg),
		.frWrite(frWrite), .resetReq(resetReq), .resetCause(resetCause),
		.winActive(winActive), .frActive(frActive), .winCount(winCount));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
	endtask
	// Reset held two edges; first request three edges after release
	task automatic rst(input logic w, input logic f);
		rstn <= 1'b0;
		optW <= w;
		optF <= f;
		cyc(2);
		rstn <= 1'b1;
		cyc(3);
	endtask
	task automatic winWr(input logic s, input logic [6:0] c, input logic [6:0] l);
		winCfg <= {s, c, l};
		winWrite <= 1'b1;
		cyc(1);
		winWrite <= 1'b0;
		cyc(1);
	endtask
	task automatic frWr(input dwd_cmd_e cm, input logic [7:0] r, input logic [2:0] p);
		frCfg <= {cm, r, p};
		frWrite <= 1'b1;
		cyc(1);
		frWrite <= 1'b0;
		cyc(1);
	endtask
	// Sparse ticks keep the low-speed rate well below the system clock
	task automatic ticks(input int k);
		repeat (k) begin
			tick <= 1'b1;
			cyc(1);
			tick <= 1'b0;
			cyc(3);
		end
	endtask
	// Bounded by a little over one window tick period
	task automatic waitCount(input logic [6:0] v);
		n = 0;
		while (winCount !== v && n < WIN_PRESCALE + 100) begin
			cyc(1);
			n++;
		end
	endtask
	task automatic tReset;
		rst(1'b0, 1'b0);
		chk({resetReq, winActive, frActive, resetCause}, 8'h00);
		chk(winCount, 8'h7F);
		$display("test reset done");
	endtask
	task automatic tEarly;
		rst(1'b0, 1'b0);
		// Start, then at once a refresh with count 0x7F above limit 0x50
		winCfg <= {1'b1, 7'h7F, 7'h50};
		winWrite <= 1'b1;
		cyc(2);
		winWrite <= 1'b0;
		cyc(3);
		chk(resetCause, 8'h02);
		chk({resetReq, winActive}, 8'h03);
		$display("test early done");
	endtask
	task automatic tStrap;
		rst(1'b1, 1'b1);
		chk({winActive, frActive}, 8'h03);
		frWr(DWD_CMD_NONE, 8'h00, 3'h0);
		winWr(1'b0, 7'h7F, 7'h7F);
		chk({winActive, frActive, resetReq}, 8'h06);
		$display("test strap done");
	endtask
	task automatic tFree;
		rst(1'b0, 1'b0);
		frWr(DWD_CMD_NONE, 8'h02, 3'h0);
		frWr(DWD_CMD_START, 8'h02, 3'h0);
		chk(frActive, 8'h01);
		ticks(8);
		frWr(DWD_CMD_REFRESH, 8'h02, 3'h0);
		ticks(11);
		chk(resetReq, 8'h00);
		ticks(1);
		cyc(2);
		chk({winActive, resetCause}, 8'h01);
		$display("test free done");
	endtask
	task automatic tPrescale;
		rst(1'b0, 1'b0);
		frWr(DWD_CMD_NONE, 8'h00, 3'h7);
		frWr(DWD_CMD_START, 8'h00, 3'h7);
		// Setup while running must be ignored, else the fire comes early
		frWr(DWD_CMD_NONE, 8'hFF, 3'h0);
		ticks(511);
		chk(resetReq, 8'h00);
		ticks(1);
		chk(resetCause, 8'h01);
		$display("test prescale done");
	endtask
	task automatic tWin;
		rst(1'b0, 1'b0);
		winWr(1'b1, 7'h41, 7'h7F);
		n = 0;
		while (resetReq !== 1'b1 && n < 30000) begin
			cyc(1);
			n++;
		end
		chk(n >= WIN_PRESCALE && n <= 2 * WIN_PRESCALE + 8, 8'h01);
		chk(resetCause, 8'h04);
		chk(winCount, 8'h3F);
		$display("test window timeout done");
	endtask
	task automatic tRefresh;
		rst(1'b0, 1'b0);
		winWr(1'b1, 7'h41, 7'h60);
		waitCount(7'h40);
		// Count 0x40 lies inside the window, so this refresh is legal
		winWr(1'b0, 7'h41, 7'h60);
		waitCount(7'h40);
		// Without the refresh the window would have expired by now
		cyc(3);
		chk({resetReq, resetCause}, 8'h00);
		chk(winCount, 8'h40);
		$display("test refresh done");
	endtask
	task automatic giveVerdict;
		$display("checks %0d mismatches %0d", totalChecks, fails);
		if (fails == 0 && totalChecks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		tReset;
		tEarly;
		tStrap;
		tFree;
		tPrescale;
		tWin;
		tRefresh;
		giveVerdict;
	end
	// Tests need about 52k cycles; this leaves a third in hand
	initial begin
		#700_000;
		fails++;
		giveVerdict;
	end
endmodule
